/* File: src/compare_out_unit.sv */
/*
 One compare output waveform flip-flop and its action decoder.
 Assumes match and TOP events are single-cycle and qualified by the tick.
*/
`timescale 1ns/1ps
`default_nettype none
module compare_out_unit #(
   parameter bit IS_A = 1'b1
) (
   input wire logic sys_clk_i, // System clock
   input wire logic rst_b_i, // Synchronous reset, active low
   wave_ctl_if.unit ctl, // Counter events
   input wire logic [1:0] field_i, // Channel output mode field
   input wire logic match_i, // Compare match pulse
   input wire logic eq_top_i, // Compare value equals TOP
   output logic wave_o // Waveform level
);
   import timer_wave_pkg::*;
   logic next_wave;
   wire toggle_ok = (field_i == 2'b01) && IS_A && ctl.wave_top;

   always_comb
   begin
      next_wave = wave_o;
      case (ctl.cls)
         CLS_NORMAL, CLS_CTC:
         begin
            if (match_i)
            begin
               if (field_i == 2'b01)
                  next_wave = ~wave_o;
               else if (field_i[1])
                  next_wave = field_i[0];
            end
         end
         CLS_FAST:
         begin
            if (toggle_ok && match_i)
               next_wave = ~wave_o;
            else if (field_i[1] && ctl.at_top)
               next_wave = ~field_i[0];
            else if (field_i[1] && match_i && !eq_top_i)
               next_wave = field_i[0];
         end
         CLS_PHASE:
         begin
            if (toggle_ok && match_i)
               next_wave = ~wave_o;
            else if (field_i[1] && eq_top_i)
            begin
               if (ctl.at_top && ctl.up)
                  next_wave = ~field_i[0];
            end
            else if (field_i[1] && match_i)
               next_wave = ctl.up ? field_i[0] : ~field_i[0];
         end
         default:
            next_wave = wave_o;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         wave_o <= 1'b0;
      else if (ctl.tick)
         wave_o <= next_wave;
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   AST_NONPWM_CLEAR: assert property ((ctl.cls == CLS_NORMAL) && match_i && (field_i == 2'b10)
      |=> !wave_o) else $error("clear on match failed");
   AST_FAST_BOTTOM: assert property ((ctl.cls == CLS_FAST) && ctl.at_top && (field_i == 2'b10)
      |=> wave_o) else $error("fast bottom set failed");
   AST_FAST_IGNORE: assert property ((ctl.cls == CLS_FAST) && match_i && eq_top_i && field_i[1]
      |=> wave_o == !$past(field_i[0])) else $error("fast top match not ignored");
   AST_PHASE_SLOPE: assert property ((ctl.cls == CLS_PHASE) && match_i && !eq_top_i
      && field_i[1] |=> wave_o == ($past(ctl.up) ~^ $past(field_i[0])))
      else $error("phase slope action wrong");
   AST_PHASE_TOP: assert property ((ctl.cls == CLS_PHASE) && ctl.at_top && ctl.up && eq_top_i
      && (field_i == 2'b11) |=> !wave_o) else $error("phase top action wrong");
   AST_RSVD_HOLD: assert property (!IS_A && (field_i == 2'b01) && (ctl.cls == CLS_FAST)
      |=> $stable(wave_o)) else $error("reserved field moved output");
   COV_FAST_MATCH: cover property ((ctl.cls == CLS_FAST) && match_i && field_i[1]);
   COV_PHASE_DOWN: cover property ((ctl.cls == CLS_PHASE) && match_i && !ctl.up);
endmodule
`default_nettype wire

/* File: src/timer_wave_pkg.sv */
/*
 Shared constants, field positions and types for the second 8-bit timer's
 waveform and compare-output control block. Assumes a single 200 MHz clock
 and an APB register bus with 12-bit byte addresses.
*/
// Overview of operation
// - Nonzero channel output mode field hands the pin to the compare output.
// - Pin driver enabled only while the port direction bit is set.
// - Non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 01 toggles only with top mode bit; 10/11 clear/set, BOTTOM opposite.
// - Fast PWM: compare equal TOP with upper bit set ignores match, BOTTOM action kept.
// - Phase PWM A: 10 clear up, set down; 11 reverse; 01 toggle with top bit.
// - Phase PWM: compare equal TOP with upper bit set ignores match, acts at TOP.
// - Non-PWM channel B decodes exactly like channel A.
// - Fast PWM B: 01 reserved; 10 non-inverting, 11 inverting.
// - Phase PWM B: 01 reserved; 10 clear up, set down; 11 reverse.
// - Control bits 3:2 read zero and ignore writes.
// - Waveform mode is top bit plus control bits 1:0, modes 0 to 7.
// - Modes 0, 1, 3 use TOP 0xFF; update and overflow points per mode.
// - Modes 5 and 7 take TOP from compare A; modes 4 and 6 reserved.
// - Counter offers normal, clear-on-match, fast PWM and phase-correct PWM.
// - Top waveform mode bit lives at bit 3 of the second control register.
package timer_wave_pkg;
   localparam logic [11:0] OFS_OUTPUT_MODE_CTRL = 12'h0B0;
   localparam logic [11:0] OFS_CLOCK_FORCE_CTRL = 12'h0B4;
   localparam logic [11:0] OFS_COMPARE_A = 12'h0B8;
   localparam logic [11:0] OFS_COMPARE_B = 12'h0BC;
   localparam logic [11:0] OFS_COUNT = 12'h0C0;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h0C4;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h0C8;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_IRQ = 3'h0;
   localparam logic [7:0] OUTPUT_MODE_WMASK = 8'hF3;
   localparam logic [7:0] CLOCK_FORCE_WMASK = 8'h09;
   localparam int A_MODE_HI = 7;
   localparam int A_MODE_LO = 6;
   localparam int B_MODE_HI = 5;
   localparam int B_MODE_LO = 4;
   localparam int WAVE_LOW_HI = 1;
   localparam int WAVE_LOW_LO = 0;
   localparam int WAVE_TOP_BIT = 3;
   localparam int RUN_BIT = 0;
   localparam int ST_OVERFLOW = 0;
   localparam int ST_MATCH_A = 1;
   localparam int ST_MATCH_B = 2;
   localparam logic [7:0] MAX_VAL = 8'hFF;
   localparam logic [7:0] BOTTOM_VAL = 8'h00;

   typedef enum logic [2:0] {CLS_NORMAL, CLS_CTC, CLS_FAST, CLS_PHASE, CLS_RSVD} wave_class_t;
endpackage

/* File: src/timer_waveform_output_control.sv */
/*
 Second 8-bit timer: mode decoder, counter, double-buffered compare values,
 compare output pins, interrupt status/mask, and an APB slave.
 Assumes an APB master on the same clock and direction bits from port logic
 on the same clock, so neither input is synchronised.
*/
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module timer_waveform_output_control (
   input wire logic sys_clk_i, // 200 MHz system clock
   input wire logic rst_b_i, // Synchronous reset, active low
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB write
   input wire logic [11:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error on unmapped address
   input wire logic dir_a_i, // Port direction bit of pin A
   input wire logic dir_b_i, // Port direction bit of pin B
   output logic wave_a_o, // Compare output A level
   output logic oe_a_o, // Pin A driver enable
   output logic override_a_o, // Pin A taken from port function
   output logic wave_b_o, // Compare output B level
   output logic oe_b_o, // Pin B driver enable
   output logic override_b_o, // Pin B taken from port function
   output logic irq_o // Level interrupt
);
   import timer_wave_pkg::*;

   function automatic wave_class_t mode_class(input logic [2:0] m);
      case (m)
         3'd0: mode_class = CLS_NORMAL;
         3'd2: mode_class = CLS_CTC;
         3'd3, 3'd7: mode_class = CLS_FAST;
         3'd1, 3'd5: mode_class = CLS_PHASE;
         default: mode_class = CLS_RSVD;
      endcase
   endfunction

   function automatic logic [7:0] next_count(input logic [7:0] c, input logic [7:0] t,
      input logic u, input wave_class_t k);
      logic [7:0] inc;
      logic [7:0] dec;
      inc = 8'(c + 8'h01);
      dec = 8'(c - 8'h01);
      case (k)
         CLS_NORMAL: next_count = inc;
         CLS_CTC, CLS_FAST: next_count = (c == t) ? BOTTOM_VAL : inc;
         CLS_PHASE:
         begin
            if (t == BOTTOM_VAL)
               next_count = BOTTOM_VAL;
            else if (u)
               next_count = (c == t) ? dec : inc;
            else
               next_count = (c == BOTTOM_VAL) ? inc : dec;
         end
         default: next_count = c;
      endcase
   endfunction

   logic [7:0] output_mode_ctrl;
   logic [7:0] clock_force_ctrl;
   logic [7:0] buf_a;
   logic [7:0] buf_b;
   logic [7:0] compare_value_a;
   logic [7:0] compare_value_b;
   logic [7:0] count;
   logic up;
   logic block;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;

   wave_ctl_if ctl ();

   // Register decode
   wire wr = psel_i && penable_i && pwrite_i;
   wire rd_setup = psel_i && !penable_i && !pwrite_i;
   wire sel_mode = (paddr_i == OFS_OUTPUT_MODE_CTRL);
   wire sel_clock = (paddr_i == OFS_CLOCK_FORCE_CTRL);
   wire sel_cmp_a = (paddr_i == OFS_COMPARE_A);
   wire sel_cmp_b = (paddr_i == OFS_COMPARE_B);
   wire sel_count = (paddr_i == OFS_COUNT);
   wire sel_stat = (paddr_i == OFS_IRQ_STATUS);
   wire sel_mask = (paddr_i == OFS_IRQ_MASK);
   wire mapped = sel_mode || sel_clock || sel_cmp_a || sel_cmp_b || sel_count
      || sel_stat || sel_mask;

   // Mode and TOP decode
   wire [2:0] waveform_mode_field = {clock_force_ctrl[WAVE_TOP_BIT],
      output_mode_ctrl[WAVE_LOW_HI:WAVE_LOW_LO]};
   wire wave_class_t cls = mode_class(waveform_mode_field);
   wire top_from_a = (waveform_mode_field == 3'd2) || waveform_mode_field[2];
   wire [7:0] top = top_from_a ? compare_value_a : MAX_VAL;
   wire tick = clock_force_ctrl[RUN_BIT] && (cls != CLS_RSVD);
   wire at_top = tick && (count == top);
   wire [1:0] channel_a_output_mode = output_mode_ctrl[A_MODE_HI:A_MODE_LO];
   wire [1:0] channel_b_output_mode = output_mode_ctrl[B_MODE_HI:B_MODE_LO];

   // A counter write suppresses the match on the following tick
   wire match_a = tick && !block && (count == compare_value_a);
   wire match_b = tick && !block && (count == compare_value_b);
   wire eq_top_a = (compare_value_a == top);
   wire eq_top_b = (compare_value_b == top);

   // Compare values: immediate in normal and CTC, at TOP in fast PWM, at TOP on the up slope in phase PWM
   wire upd_imm = (cls == CLS_NORMAL) || (cls == CLS_CTC);
   wire upd_now = upd_imm || (cls == CLS_FAST && at_top)
      || (cls == CLS_PHASE && at_top && up);

   wire overflow_flag = ((cls == CLS_NORMAL || cls == CLS_CTC) && tick && count == MAX_VAL)
      || (cls == CLS_FAST && at_top)
      || (cls == CLS_PHASE && tick && count == BOTTOM_VAL && !up);
   wire [2:0] events = {match_b, match_a, overflow_flag};
   wire [2:0] clr_bits = (wr && sel_stat) ? pwdata_i[2:0] : 3'h0;
   // Set wins over a same-cycle clear, so no event is lost
   wire [2:0] next_irq_status = (irq_status & ~clr_bits) | events;

   wire [7:0] next_up_count = next_count(count, top, up, cls);

   logic [31:0] read_mux;
   always_comb
   begin
      read_mux = 32'h0000_0000;
      if (sel_mode)
         read_mux = {24'h00_0000, output_mode_ctrl & OUTPUT_MODE_WMASK};
      else if (sel_clock)
         read_mux = {24'h00_0000, clock_force_ctrl};
      else if (sel_cmp_a)
         read_mux = {24'h00_0000, buf_a};
      else if (sel_cmp_b)
         read_mux = {24'h00_0000, buf_b};
      else if (sel_count)
         read_mux = {24'h00_0000, count};
      else if (sel_stat)
         read_mux = {29'h0000_0000, irq_status};
      else if (sel_mask)
         read_mux = {29'h0000_0000, irq_mask};
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         output_mode_ctrl <= RST_BYTE;
         clock_force_ctrl <= RST_BYTE;
         irq_mask <= RST_IRQ;
      end
      else if (wr)
      begin
         if (sel_mode)
            output_mode_ctrl <= pwdata_i[7:0] & OUTPUT_MODE_WMASK;
         if (sel_clock)
            clock_force_ctrl <= pwdata_i[7:0] & CLOCK_FORCE_WMASK;
         if (sel_mask)
            irq_mask <= pwdata_i[2:0];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         buf_a <= RST_BYTE;
         buf_b <= RST_BYTE;
      end
      else if (wr)
      begin
         if (sel_cmp_a)
            buf_a <= pwdata_i[7:0];
         if (sel_cmp_b)
            buf_b <= pwdata_i[7:0];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         compare_value_a <= RST_BYTE;
         compare_value_b <= RST_BYTE;
      end
      else if (upd_now)
      begin
         compare_value_a <= buf_a;
         compare_value_b <= buf_b;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         count <= BOTTOM_VAL;
         block <= 1'b0;
      end
      else if (wr && sel_count)
      begin
         count <= pwdata_i[7:0];
         block <= 1'b1;
      end
      else if (tick)
      begin
         count <= next_up_count;
         block <= 1'b0;
      end
   end

   // Slope direction, only meaningful in phase-correct modes
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         up <= 1'b1;
      else if (cls != CLS_PHASE)
         up <= 1'b1;
      else if (at_top && up && top != BOTTOM_VAL)
         up <= 1'b0;
      else if (tick && !up && count == BOTTOM_VAL)
         up <= 1'b1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         irq_status <= RST_IRQ;
         prdata_o <= 32'h0000_0000;
      end
      else
      begin
         irq_status <= next_irq_status;
         if (rd_setup)
            prdata_o <= read_mux;
      end
   end

   assign ctl.tick = tick;
   assign ctl.cls = cls;
   assign ctl.up = up;
   assign ctl.at_top = at_top;
   assign ctl.wave_top = waveform_mode_field[2];

   compare_out_unit #(.IS_A(1'b1)) unit_a (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .ctl(ctl),
      .field_i(channel_a_output_mode),
      .match_i(match_a),
      .eq_top_i(eq_top_a),
      .wave_o(wave_a_o)
   );

   compare_out_unit #(.IS_A(1'b0)) unit_b (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .ctl(ctl),
      .field_i(channel_b_output_mode),
      .match_i(match_b),
      .eq_top_i(eq_top_b),
      .wave_o(wave_b_o)
   );

   assign override_a_o = |channel_a_output_mode;
   assign override_b_o = |channel_b_output_mode;
   assign oe_a_o = override_a_o && dir_a_i;
   assign oe_b_o = override_b_o && dir_b_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;
   assign irq_o = |(irq_status & irq_mask);

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   AST_PIN_TAKEOVER: assert property (wr && sel_mode && (pwdata_i[7:6] != 2'b00)
      |=> override_a_o) else $error("pin A not taken over");
   AST_DRIVER_DIR: assert property ((oe_a_o |-> dir_a_i) and (oe_b_o |-> dir_b_i))
      else $error("driver enabled without direction bit");
   AST_RSVD_READ: assert property (psel_i && penable_i && !pwrite_i && sel_mode
      |-> prdata_o[3:2] == 2'b00) else $error("reserved bits read nonzero");
   AST_MODE_TOP_BIT: assert property (wr && sel_clock
      |=> waveform_mode_field[2] == $past(pwdata_i[3])) else $error("mode top bit lost");
   AST_MODE_LOW: assert property (wr && sel_mode
      |=> waveform_mode_field[1:0] == $past(pwdata_i[1:0])) else $error("mode low bits lost");
   AST_TOP_FIXED: assert property ((waveform_mode_field == 3'd1 || waveform_mode_field == 3'd3)
      |-> top == 8'hFF) else $error("fixed TOP wrong");
   AST_TOP_FROM_A: assert property ((waveform_mode_field == 3'd5 || waveform_mode_field == 3'd7)
      |-> top == compare_value_a) else $error("TOP not from compare A");
   AST_PHASE_TURN: assert property ((cls == CLS_PHASE) && at_top && up && (top != 8'h00)
      |=> !up ##1 (count != 8'hFF)) else $error("phase counter failed to turn");
   AST_MATCH_FLAG: assert property (match_a |=> irq_status[ST_MATCH_A])
      else $error("match A not flagged");
   AST_SET_WINS: assert property (overflow_flag && wr && sel_stat && pwdata_i[ST_OVERFLOW]
      |=> irq_status[ST_OVERFLOW]) else $error("overflow lost under clear");
   COV_IRQ: cover property (irq_o);
   COV_PHASE: cover property ((cls == CLS_PHASE) && at_top ##[1:600] overflow_flag);
   COV_CTC_WRAP: cover property ((cls == CLS_CTC) && at_top ##1 count == 8'h00);
endmodule
`default_nettype wire

/* File: src/wave_ctl_if.sv */
/*
 Timing events shared between the counter core and the compare output units.
 Assumes every signal is generated on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface wave_ctl_if;
   import timer_wave_pkg::*;
   logic tick;
   wave_class_t cls;
   logic up;
   logic at_top;
   logic wave_top;
   modport src (output tick, output cls, output up, output at_top, output wave_top);
   modport unit (input tick, input cls, input up, input at_top, input wave_top);
endinterface
`default_nettype wire

/* File: test/tb_top.sv */
/*
 Self-checking bench for the timer waveform and compare-output block.
 Assumes one 200 MHz clock, an APB master driven here, and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import timer_wave_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic dir_a_i = 1'b1;
   logic dir_b_i = 1'b1;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, wave_a_o, oe_a_o, override_a_o;
   logic wave_b_o, oe_b_o, override_b_o, irq_o;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int t0 = 0;

   timer_waveform_output_control i_timer_waveform_output_control (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .dir_a_i(dir_a_i), .dir_b_i(dir_b_i),
      .wave_a_o(wave_a_o), .oe_a_o(oe_a_o), .override_a_o(override_a_o),
      .wave_b_o(wave_b_o), .oe_b_o(oe_b_o), .override_b_o(override_b_o),
      .irq_o(irq_o));

   always #2.5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) cyc <= cyc + 1;

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1)
      begin
         fail_count++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(what, r & m, exp);
   endtask

   task automatic do_reset;
      @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
   endtask

   // Compares are loaded in mode 0 first so the active copies are valid from the start
   task automatic start(input logic [7:0] ctl, input logic top, input logic [7:0] ca,
      input logic [7:0] cb);
      do_reset();
      wr(OFS_COMPARE_A, {24'h00_0000, ca});
      wr(OFS_COMPARE_B, {24'h00_0000, cb});
      wr(OFS_OUTPUT_MODE_CTRL, {24'h00_0000, ctl});
      wr(OFS_CLOCK_FORCE_CTRL, {28'h000_0000, top, 3'h1});
      t0 = cyc;
   endtask

   // Checks sit far from any edge of the pattern, so a cycle of latency is harmless
   task automatic pins(input int c, input logic a, input logic b);
      @(negedge sys_clk_i);
      while (cyc < t0 + c)
         @(negedge sys_clk_i);
      check("wave_a", wave_a_o, a);
      check("wave_b", wave_b_o, b);
   endtask

   task automatic outs(input logic va, input logic ea, input logic vb, input logic eb);
      @(negedge sys_clk_i);
      check("override_a", override_a_o, va);
      check("oe_a", oe_a_o, ea);
      check("override_b", override_b_o, vb);
      check("oe_b", oe_b_o, eb);
   endtask

   task automatic sc_regs;
      logic [31:0] r;
      logic e;
      rd_chk("mode_ctrl", OFS_OUTPUT_MODE_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk("clk_ctrl", OFS_CLOCK_FORCE_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk("irq_mask", OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(OFS_OUTPUT_MODE_CTRL, 32'h0000_00FF);
      rd_chk("mode_ctrl", OFS_OUTPUT_MODE_CTRL, 32'hFFFF_FFFF, 32'h0000_00F3);
      wr(OFS_CLOCK_FORCE_CTRL, 32'h0000_00FF);
      rd_chk("clk_ctrl", OFS_CLOCK_FORCE_CTRL, 32'hFFFF_FFFF, 32'h0000_0009);
      apb(1'b0, 12'h0D0, 32'h0000_0000, r, e);
      check("unmapped_err", e, 32'h0000_0001);
      check("unmapped_data", r, 32'h0000_0000);
      dir_a_i <= 1'b0;
      outs(1'b1, 1'b0, 1'b1, 1'b1);
      wr(OFS_OUTPUT_MODE_CTRL, 32'h0000_0040);
      dir_a_i <= 1'b1;
      dir_b_i <= 1'b0;
      outs(1'b1, 1'b1, 1'b0, 1'b0);
      wr(OFS_OUTPUT_MODE_CTRL, 32'h0000_0010);
      dir_b_i <= 1'b1;
      outs(1'b0, 1'b0, 1'b1, 1'b1);
   endtask

   task automatic sc_normal;
      start(8'h70, 1'b0, 8'h10, 8'h20);
      pins(32'h40, 1'b1, 1'b1);
      pins(32'h140, 1'b0, 1'b1);
      wr(OFS_CLOCK_FORCE_CTRL, 32'h0000_0000);
      rd_chk("status", OFS_IRQ_STATUS, 32'hFFFF_FFFF, 32'h0000_0007);
      check("irq", irq_o, 1'b0);
      wr(OFS_IRQ_MASK, 32'h0000_0002);
      @(negedge sys_clk_i);
      check("irq", irq_o, 1'b1);
      wr(OFS_IRQ_STATUS, 32'h0000_0002);
      @(negedge sys_clk_i);
      check("irq", irq_o, 1'b0);
      rd_chk("status", OFS_IRQ_STATUS, 32'hFFFF_FFFF, 32'h0000_0005);
      rd_chk("irq_mask", OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0002);
      wr(OFS_IRQ_MASK, 32'h0000_0005);
      @(negedge sys_clk_i);
      check("irq", irq_o, 1'b1);
      wr(OFS_IRQ_STATUS, 32'h0000_0005);
      @(negedge sys_clk_i);
      check("irq", irq_o, 1'b0);
   endtask

   initial
   begin
      repeat (6) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      sc_regs();
      sc_normal();
      start(8'h42, 1'b0, 8'h1F, 8'h00);
      pins(32'h30, 1'b1, 1'b0);
      pins(32'h50, 1'b0, 1'b0);
      check("override_b", override_b_o, 1'b0);
      rd_chk("status", OFS_IRQ_STATUS, 32'h0000_0003, 32'h0000_0002);
      start(8'hB3, 1'b0, 8'h40, 8'h40);
      pins(32'h80, 1'b0, 1'b1);
      rd_chk("overflow", OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0000);
      pins(32'h120, 1'b1, 1'b0);
      rd_chk("overflow", OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      pins(32'h180, 1'b0, 1'b1);
      start(8'hA3, 1'b1, 8'h3F, 8'h10);
      pins(32'h20, 1'b0, 1'b0);
      pins(32'h48, 1'b1, 1'b1);
      pins(32'h60, 1'b1, 1'b0);
      rd_chk("overflow", OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      start(8'hB1, 1'b0, 8'h40, 8'h40);
      pins(32'h80, 1'b0, 1'b1);
      rd_chk("overflow", OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0000);
      pins(32'h1E0, 1'b1, 1'b0);
      pins(32'h210, 1'b1, 1'b0);
      rd_chk("overflow", OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      start(8'hA1, 1'b1, 8'h40, 8'h20);
      pins(32'h30, 1'b0, 1'b0);
      pins(32'h70, 1'b1, 1'b1);
      pins(32'hB0, 1'b1, 1'b0);
      rd_chk("overflow", OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      tally_and_finish();
   end
endmodule
`default_nettype wire
